// File: core/gscp_pkg.sv
// Purpose: shared constants and types of the gauge serial command port
// Assumes: 100 MHz device clock, 8N1 serial line
// Notes: ascii control codes and timing counts live here only
package gscp_pkg;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_ENQ = 8'h05;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_TILDE = 8'h7e;
  localparam logic [7:0] CH_C = 8'h43;
  localparam logic [7:0] CH_O = 8'h4f;
  localparam logic [7:0] CH_M = 8'h4d;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_HEX_A = 8'h37;
  localparam int CLK_HZ = 100000000;
  localparam int STREAM_PERIOD_MS = 1000;
  localparam int STREAM_CYCLES = STREAM_PERIOD_MS * (CLK_HZ / 1000);
  localparam int DATA_BITS = 8;
  localparam int MNEM_LEN = 3;
  localparam logic [2:0] LEN_SHORT = 3'h3;
  localparam logic [2:0] LEN_LONG = 3'h6;
  localparam logic [15:0] BAUD_DIV_RST = 16'h0364;
  // error word value is arbitrary
  localparam logic [15:0] ERR_WORD_DEF = 16'hee00;

  typedef struct packed {
    logic [7:0] c0;
    logic [7:0] c1;
    logic [7:0] c2;
  } gscp_cmd_s;

  typedef enum logic [3:0] {
    LN_IDLE = 4'h1,
    LN_START = 4'h2,
    LN_DATA = 4'h4,
    LN_STOP = 4'h8
  } gscp_line_e;

  typedef enum logic [1:0] {
    MSG_ACK = 2'h0,
    MSG_NAK = 2'h1,
    MSG_DATA = 2'h2,
    MSG_ERRW = 2'h3
  } gscp_msg_e;
endpackage

// File: core/gscp_port.sv
// Purpose: serial command port: streaming, command framing, acknowledge replies
// Assumes: rxd synchronous to clock, baud_div steady while the line is busy
// Notes: accepted commands leave through a two-entry buffer towards the user
//
// How it works
// - from reset, measured value sent every second on its own
// - any received character stops the periodic stream
// - stream stays off until restart_continuous_output command resumes it
// - each character framed 1 start, 8 data, no parity, 1 stop
// - receiver and transmitter run independently in both directions
// - end-of-text 03h clears partial input and interface state
// - terminators use carriage return 0Dh and line feed 0Ah
// - enquiry 05h requests a data string
// - every string answered by ACK 06h or NAK 15h, then CR LF
// - three character mnemonics; spaces ignored
// - enquiry without valid request answers with the error word
// - bad string or framing error answered with NAK CR LF
`timescale 1ns/1ps
`default_nettype none
module gscp_port
  import gscp_pkg::*;
#(
  parameter int STREAM_CNT = STREAM_CYCLES,
  parameter logic [15:0] ERR_WORD = ERR_WORD_DEF
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [15:0] baud_div,
  input wire logic rxd,
  output logic txd,
  input wire logic [15:0] meas_value,
  output logic cmd_valid,
  input wire logic cmd_ready,
  output gscp_cmd_s cmd_data,
  output logic stream_on
);

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? (CH_ZERO + {4'h0, n}) : (CH_HEX_A + {4'h0, n});
  endfunction

  function automatic logic [7:0] msg_byte(input gscp_msg_e k, input logic [2:0] i,
                                          input logic [15:0] w);
    logic [7:0] b;
    b = CH_LF;
    if (k == MSG_ACK || k == MSG_NAK)
    begin
      case (i)
        3'h0: b = (k == MSG_ACK) ? CH_ACK : CH_NAK;
        3'h1: b = CH_CR;
        default: b = CH_LF;
      endcase
    end
    else
    begin
      case (i)
        3'h0: b = hex_char(w[15:12]);
        3'h1: b = hex_char(w[11:8]);
        3'h2: b = hex_char(w[7:4]);
        3'h3: b = hex_char(w[3:0]);
        3'h4: b = CH_CR;
        default: b = CH_LF;
      endcase
    end
    msg_byte = b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // receiver
  gscp_line_e rx_st_r;
  logic [15:0] rx_cnt_r;
  logic [2:0] rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_v_r;
  logic rx_ferr_r;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      rx_st_r <= LN_IDLE;
      rx_cnt_r <= 16'h0000;
      rx_bit_r <= 3'h0;
      rx_sh_r <= 8'h00;
      rx_v_r <= 1'b0;
      rx_ferr_r <= 1'b0;
    end
    else
    begin
      rx_v_r <= 1'b0;
      if (rx_cnt_r != 16'h0000)
        rx_cnt_r <= rx_cnt_r - 16'h0001;
      case (rx_st_r)
        LN_IDLE:
          if (!rxd)
          begin
            rx_st_r <= LN_START;
            rx_cnt_r <= {1'b0, baud_div[15:1]};
          end
        LN_START:
          if (rx_cnt_r == 16'h0000)
          begin
            rx_st_r <= rxd ? LN_IDLE : LN_DATA;
            rx_cnt_r <= baud_div;
            rx_bit_r <= 3'h0;
          end
        LN_DATA:
          if (rx_cnt_r == 16'h0000)
          begin
            rx_sh_r <= {rxd, rx_sh_r[7:1]};
            rx_cnt_r <= baud_div;
            rx_bit_r <= rx_bit_r + 3'h1;
            if (rx_bit_r == 3'(DATA_BITS - 1))
              rx_st_r <= LN_STOP;
          end
        LN_STOP:
          if (rx_cnt_r == 16'h0000)
          begin
            rx_st_r <= LN_IDLE;
            rx_v_r <= 1'b1;
            rx_ferr_r <= !rxd;
          end
        default:
          rx_st_r <= LN_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line parser
  logic [2:0] len_r;
  logic bad_r;
  logic req_ok_r;
  gscp_cmd_s mnem_r;
  logic [1:0] cnt_r;
  logic push;
  logic full;
  logic want_reply;
  gscp_msg_e want_kind;
  logic is_restart;
  logic printable;

  assign full = (cnt_r == 2'h2);
  assign is_restart = (mnem_r.c0 == CH_C) && (mnem_r.c1 == CH_O) && (mnem_r.c2 == CH_M);
  assign printable = (rx_sh_r > CH_SPACE) && (rx_sh_r <= CH_TILDE);

  always_comb
  begin
    push = 1'b0;
    want_reply = 1'b0;
    want_kind = MSG_ACK;
    if (rx_v_r && rx_sh_r == CH_ENQ)
    begin
      want_reply = 1'b1;
      want_kind = req_ok_r ? MSG_DATA : MSG_ERRW;
    end
    else if (rx_v_r && rx_sh_r == CH_CR)
    begin
      want_reply = 1'b1;
      if (len_r == 3'(MNEM_LEN) && !bad_r && !rx_ferr_r && !full)
        push = 1'b1;
      want_kind = push ? MSG_ACK : MSG_NAK;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      len_r <= 3'h0;
      bad_r <= 1'b0;
      req_ok_r <= 1'b0;
      mnem_r <= '0;
    end
    else if (rx_v_r)
    begin
      if (rx_sh_r == CH_ETX)
      begin
        len_r <= 3'h0;
        bad_r <= 1'b0;
        req_ok_r <= 1'b0;
      end
      else if (rx_sh_r == CH_CR)
      begin
        len_r <= 3'h0;
        bad_r <= 1'b0;
        req_ok_r <= push;
      end
      else if (rx_sh_r == CH_SPACE || rx_sh_r == CH_LF || rx_sh_r == CH_ENQ)
        bad_r <= bad_r | rx_ferr_r;
      else if (!printable || rx_ferr_r)
        bad_r <= 1'b1;
      else if (len_r < 3'(MNEM_LEN))
      begin
        len_r <= len_r + 3'h1;
        case (len_r)
          3'h0: mnem_r.c0 <= rx_sh_r;
          3'h1: mnem_r.c1 <= rx_sh_r;
          default: mnem_r.c2 <= rx_sh_r;
        endcase
      end
      // parameters after the mnemonic are dropped, checked only for printable characters and framing errors
    end
  end

  // stream control: set by restart wins over the stop of the same cr
  always_ff @(posedge clock)
  begin
    if (!nrst)
      stream_on <= 1'b1;
    else if (push && is_restart)
      stream_on <= 1'b1;
    else if (rx_v_r)
      stream_on <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry command buffer, head register drives the user side
  gscp_cmd_s tail_r;
  logic pop;

  assign pop = cmd_valid && cmd_ready;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      cnt_r <= 2'h0;
      cmd_valid <= 1'b0;
      cmd_data <= '0;
      tail_r <= '0;
    end
    else
    begin
      case ({push, pop})
        2'b10:
        begin
          if (cnt_r == 2'h0)
            cmd_data <= mnem_r;
          else
            tail_r <= mnem_r;
          cnt_r <= cnt_r + 2'h1;
          cmd_valid <= 1'b1;
        end
        2'b01:
        begin
          cmd_data <= tail_r;
          cnt_r <= cnt_r - 2'h1;
          cmd_valid <= (cnt_r == 2'h2);
        end
        2'b11:
        begin
          if (cnt_r == 2'h1)
            cmd_data <= mnem_r;
          else
          begin
            cmd_data <= tail_r;
            tail_r <= mnem_r;
          end
        end
        default:
          cnt_r <= cnt_r;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // period timer and reply request flags
  logic [31:0] per_cnt_r;
  logic due_r;
  logic pend_r;
  gscp_msg_e pend_kind_r;
  logic start_msg;
  logic start_reply;

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      per_cnt_r <= 32'h0000_0000;
      due_r <= 1'b1;
    end
    else
    begin
      if (per_cnt_r == 32'(STREAM_CNT - 1))
        per_cnt_r <= 32'h0000_0000;
      else
        per_cnt_r <= per_cnt_r + 32'h0000_0001;
      // set wins over the clear of a starting stream message
      if (per_cnt_r == 32'(STREAM_CNT - 1))
        due_r <= 1'b1;
      else if (start_msg && !start_reply)
        due_r <= 1'b0;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      pend_r <= 1'b0;
      pend_kind_r <= MSG_ACK;
    end
    else if (want_reply)
    begin
      pend_r <= 1'b1;
      pend_kind_r <= want_kind;
    end
    else if (start_reply)
      pend_r <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // message sequencer and transmitter
  gscp_line_e tx_st_r;
  logic [15:0] tx_cnt_r;
  logic [2:0] tx_bit_r;
  logic [7:0] tx_sh_r;
  logic busy_r;
  gscp_msg_e kind_r;
  logic [2:0] idx_r;
  logic [15:0] word_r;

  assign start_reply = !busy_r && pend_r;
  assign start_msg = !busy_r && (pend_r || (due_r && stream_on));

  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      busy_r <= 1'b0;
      kind_r <= MSG_ACK;
      idx_r <= 3'h0;
      word_r <= 16'h0000;
      tx_st_r <= LN_IDLE;
      tx_cnt_r <= 16'h0000;
      tx_bit_r <= 3'h0;
      tx_sh_r <= 8'h00;
      txd <= 1'b1;
    end
    else
    begin
      if (start_msg)
      begin
        busy_r <= 1'b1;
        idx_r <= 3'h0;
        kind_r <= start_reply ? pend_kind_r : MSG_DATA;
        word_r <= (start_reply && pend_kind_r == MSG_ERRW) ? ERR_WORD : meas_value;
      end
      if (tx_cnt_r != 16'h0000)
        tx_cnt_r <= tx_cnt_r - 16'h0001;
      case (tx_st_r)
        LN_IDLE:
          if (busy_r)
          begin
            tx_sh_r <= msg_byte(kind_r, idx_r, word_r);
            txd <= 1'b0;
            tx_cnt_r <= baud_div;
            tx_st_r <= LN_START;
          end
        LN_START:
          if (tx_cnt_r == 16'h0000)
          begin
            txd <= tx_sh_r[0];
            tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            tx_bit_r <= 3'h0;
            tx_cnt_r <= baud_div;
            tx_st_r <= LN_DATA;
          end
        LN_DATA:
          if (tx_cnt_r == 16'h0000)
          begin
            tx_cnt_r <= baud_div;
            tx_bit_r <= tx_bit_r + 3'h1;
            if (tx_bit_r == 3'(DATA_BITS - 1))
            begin
              txd <= 1'b1;
              tx_st_r <= LN_STOP;
            end
            else
            begin
              txd <= tx_sh_r[0];
              tx_sh_r <= {1'b0, tx_sh_r[7:1]};
            end
          end
        LN_STOP:
          if (tx_cnt_r == 16'h0000)
          begin
            tx_st_r <= LN_IDLE;
            idx_r <= idx_r + 3'h1;
            if (idx_r == ((kind_r == MSG_ACK || kind_r == MSG_NAK) ? LEN_SHORT : LEN_LONG)
                        - 3'h1)
              busy_r <= 1'b0;
          end
        default:
          tx_st_r <= LN_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: tb/gscp_port_props.sv
// Purpose: port checks of the serial command port
// Assumes: baud_div 7 whenever a frame is timed
// Notes: bound in tb
`timescale 1ns/1ps
`default_nettype none
module gscp_port_props
  import gscp_pkg::*;
#(
  parameter int STREAM_CNT = STREAM_CYCLES,
  parameter logic [15:0] ERR_WORD = ERR_WORD_DEF
)
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic [15:0] baud_div,
  input wire logic rxd,
  input wire logic txd,
  input wire logic [15:0] meas_value,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire gscp_cmd_s cmd_data,
  input wire logic stream_on
);
  // cycles since rxd was last low, saturating
  logic [7:0] quiet_r;
  always_ff @(posedge clock)
  begin
    if (!nrst || !rxd)
      quiet_r <= 8'h00;
    else if (quiet_r != 8'hff)
      quiet_r <= quiet_r + 8'h01;
  end
  // position inside a sent frame, so falling data edges are not taken as start bits
  logic [6:0] tx_pos_r;
  logic txd_q_r;
  always_ff @(posedge clock)
  begin
    if (!nrst)
    begin
      tx_pos_r <= 7'h00;
      txd_q_r <= 1'b1;
    end
    else
    begin
      txd_q_r <= txd;
      if (tx_pos_r == 7'h4f)
        tx_pos_r <= 7'h00;
      else if (tx_pos_r != 7'h00 || (txd_q_r && !txd))
        tx_pos_r <= tx_pos_r + 7'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence start_s;
    $fell(txd) && tx_pos_r == 7'h00 && baud_div == 16'h0007;
  endsequence
  sequence stop_s;
    ##72 txd [*8];
  endsequence
  reset_vals_a: assert property ($rose(nrst) |-> txd && !cmd_valid && stream_on)
    else $error("outputs wrong after reset");
  first_stream_a: assert property ($rose(nrst) |-> ##[1:6] !txd)
    else $error("no stream after reset");
  start_bit_a: assert property (start_s |-> (!txd) [*8])
    else $error("start bit too short");
  stop_bit_a: assert property (start_s |-> stop_s)
    else $error("stop bit missing");
  cmd_hold_a: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
    else $error("command lost while stalled");
  cmd_pop_a: assert property ($fell(cmd_valid) && $past(nrst) |-> $past(cmd_ready))
    else $error("command dropped without pop");
  stop_cause_a: assert property ($fell(stream_on) |-> quiet_r < 8'h64)
    else $error("stream stopped with no character");
  restart_cmd_a: assert property ($rose(stream_on) && $past(nrst) |-> ##[0:1] cmd_valid)
    else $error("stream restarted with no command");
endmodule
`default_nettype wire

// File: tb/gscp_host_model.sv
// Purpose: host side of the serial line
// Assumes: bit period of BIT_CYC clocks
// Notes: unbounded receive queue
`timescale 1ns/1ps
`default_nettype none
module gscp_host_model
#(
  parameter int BIT_CYC = 8
)
(
  input wire logic clock,
  output var logic rxd,
  input wire logic txd
);
  logic [7:0] rx_q[$];
  initial rxd = 1'b1;
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clock);
      rxd <= fr[i];
      repeat (BIT_CYC - 1) @(negedge clock);
    end
  endtask
  // receiver runs apart from the sender
  initial
  forever
  begin
    logic [7:0] b;
    @(negedge clock);
    if (txd === 1'b0)
    begin
      repeat (BIT_CYC / 2) @(negedge clock);
      for (int i = 0; i < 8; i++)
      begin
        repeat (BIT_CYC) @(negedge clock);
        b[i] = txd;
      end
      repeat (BIT_CYC) @(negedge clock);
      if (txd === 1'b1)
        rx_q.push_back(b);
    end
  end
endmodule
`default_nettype wire

// File: tb/tb.sv
// Purpose: bench of the serial command port
// Assumes: baud_div 7, short stream period
// Notes: cmd_ready low until the pops
`timescale 1ns/1ps
`default_nettype none
module tb;
  import gscp_pkg::*;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic cmd_ready = 1'b0;
  logic [15:0] baud_div = 16'h0007;
  logic [15:0] meas_value = 16'h3a5c;
  logic rxd;
  logic txd;
  logic cmd_valid;
  logic stream_on;
  gscp_cmd_s cmd_data;
  int fail_count = 0;
  int n_compared = 0;
  always #5 clock = ~clock;
  gscp_port #(.STREAM_CNT(20000)) DUT (.clock(clock), .nrst(nrst), .baud_div(baud_div),
    .rxd(rxd), .txd(txd), .meas_value(meas_value), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_data(cmd_data), .stream_on(stream_on));
  gscp_host_model #(.BIT_CYC(8)) host (.clock(clock), .rxd(rxd), .txd(txd));
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic string hex4(input logic [15:0] v);
    string s;
    s = $sformatf("%h", v);
    return s.toupper();
  endfunction
  task automatic send_str(input string s);
    for (int i = 0; i < s.len(); i++)
      host.send_byte(s[i]);
  endtask
  task automatic expect_msg(input string body, input int bound);
    string s;
    int n;
    s = {body, "\015\012"};
    n = 0;
    while (host.rx_q.size() < s.len() && n < bound)
    begin
      @(negedge clock);
      n++;
    end
    if (host.rx_q.size() < s.len())
    begin
      fail_count++;
      $display("ERROR reply length expected %0d seen %0d", s.len(), host.rx_q.size());
      results();
    end
    for (int i = 0; i < s.len(); i++)
      check("reply byte", {16'h0000, s[i]}, {16'h0000, host.rx_q.pop_front()});
  endtask
  task automatic pop(input logic [23:0] exp);
    check("head", exp, cmd_data);
    cmd_ready = 1'b1;
    @(negedge clock);
    cmd_ready = 1'b0;
    @(negedge clock);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_stream();
    expect_msg(hex4(meas_value), 3000);
    check("stream flag", 24'h1, stream_on);
    expect_msg(hex4(meas_value), 25000);
  endtask
  task automatic t_quiet();
    send_str("\003");
    repeat (4) @(negedge clock);
    check("stream flag", 24'h0, stream_on);
    repeat (22000) @(negedge clock);
    check("bytes while quiet", 24'h0, host.rx_q.size());
    send_str("\005");
    expect_msg(hex4(ERR_WORD_DEF), 3000);
    send_str("AB\015");
    expect_msg("\025", 3000);
  endtask
  task automatic t_cmd();
    // etx mid-string drops the partial mnemonic
    send_str("AB\003C DE\015");
    expect_msg("\006", 3000);
    check("valid", 24'h1, cmd_valid);
    send_str("\005");
    expect_msg(hex4(meas_value), 3000);
    send_str("XYZ,1\015");
    expect_msg("\006", 3000);
    send_str("QRS\015");
    expect_msg("\025", 3000);
    pop("CDE");
    pop("XYZ");
    check("valid after pops", 24'h0, cmd_valid);
  endtask
  task automatic t_restart();
    host.send_byte(CH_C);
    host.send_byte(CH_O);
    host.send_byte(CH_M);
    send_str("\015");
    expect_msg("\006", 3000);
    check("stream flag", 24'h1, stream_on);
    pop({CH_C, CH_O, CH_M});
    expect_msg(hex4(meas_value), 25000);
  endtask
  initial
  begin
    repeat (4) @(negedge clock);
    nrst = 1'b1;
    t_stream();
    t_quiet();
    t_cmd();
    t_restart();
    results();
  end
endmodule
bind gscp_port gscp_port_props #(.STREAM_CNT(STREAM_CNT), .ERR_WORD(ERR_WORD)) props (
  .clock(clock), .nrst(nrst), .baud_div(baud_div), .rxd(rxd), .txd(txd),
  .meas_value(meas_value), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
  .cmd_data(cmd_data), .stream_on(stream_on));
`default_nettype wire
